// >>> shared/uvra_pkg.sv
package uvra_pkg;

  // request framing of the vendor control transfers
  localparam logic [7:0] UVRA_REQTYPE_VENDOR_IN = 8'hC0;
  localparam logic [7:0] UVRA_REQTYPE_VENDOR_OUT = 8'h40;
  localparam logic [7:0] UVRA_REQ_READ = 8'h0D;
  localparam logic [7:0] UVRA_REQ_WRITE = 8'h0E;
  localparam logic [15:0] UVRA_READ_VALUE = 16'h0000;
  localparam logic [15:0] UVRA_READ_LENGTH = 16'h0001;
  localparam logic [15:0] UVRA_WRITE_LENGTH = 16'h0000;

  // register indices
  localparam logic [15:0] UVRA_IDX_PORT1_LINE_SETUP = 16'h0000;
  localparam logic [15:0] UVRA_IDX_PORT1_CONTROL = 16'h0001;
  localparam logic [15:0] UVRA_IDX_BUFFER_TOGGLE_UPPER = 16'h0002;
  localparam logic [15:0] UVRA_IDX_BUFFER_TOGGLE_LOWER = 16'h0003;
  localparam logic [15:0] UVRA_IDX_PORT2_LINE_SETUP = 16'h000A;
  localparam logic [15:0] UVRA_IDX_PORT2_CONTROL = 16'h000B;
  localparam logic [15:0] UVRA_IDX_SYNTH_MULTIPLIER = 16'h000E;
  localparam logic [15:0] UVRA_IDX_SYNTH_DIVIDER = 16'h0010;
  localparam logic [15:0] UVRA_IDX_CLOCK_SOURCE_MUX = 16'h0012;
  localparam logic [15:0] UVRA_IDX_CLOCK_CHOICE_FIRST = 16'h0013;
  localparam logic [15:0] UVRA_IDX_CLOCK_CHOICE_SECOND = 16'h0014;
  localparam logic [15:0] UVRA_IDX_STRAP_MODE_STATUS = 16'h002B;
  localparam logic [15:0] UVRA_IDX_PORT1_CHAR_GAP = 16'h002C;
  localparam logic [15:0] UVRA_IDX_PORT2_CHAR_GAP = 16'h002E;
  localparam logic [15:0] UVRA_IDX_RECEIVE_SAMPLE_POINT = 16'h0030;
  localparam logic [15:0] UVRA_IDX_PORT1_UPSTREAM_FIFO = 16'h0032;
  localparam logic [15:0] UVRA_IDX_PORT1_DOWNSTREAM_FIFO = 16'h0033;
  localparam logic [15:0] UVRA_IDX_PORT2_UPSTREAM_FIFO = 16'h0036;
  localparam logic [15:0] UVRA_IDX_PORT2_DOWNSTREAM_FIFO = 16'h0037;
  localparam logic [15:0] UVRA_IDX_EMPTY_PACKET_CTL_FIRST = 16'h003A;
  localparam logic [15:0] UVRA_IDX_EMPTY_PACKET_CTL_SECOND = 16'h003C;
  localparam logic [15:0] UVRA_IDX_EMPTY_PACKET_FLAG_ENABLE = 16'h003E;

  // writable masks and reset value of the stored registers
  localparam logic [7:0] UVRA_MASK_FULL = 8'hFF;
  localparam logic [7:0] UVRA_MASK_SIX = 8'h3F;
  localparam logic [7:0] UVRA_MASK_FOUR = 8'h0F;
  localparam logic [7:0] UVRA_MASK_SEVEN = 8'h7F;
  localparam logic [7:0] UVRA_REG_RESET = 8'h00;
  localparam logic [7:0] UVRA_UNMAPPED_BYTE = 8'h00;

  // stored register slots
  localparam int UVRA_SLOT_COUNT = 17;
  localparam int UVRA_SLOT_P1_LINE = 0;
  localparam int UVRA_SLOT_TOG_LOWER = 3;
  localparam int UVRA_SLOT_P2_LINE = 4;
  localparam int UVRA_SLOT_MULT = 6;
  localparam int UVRA_SLOT_MUX = 8;

  // slot tables, slot 16 leftmost down to slot 0 rightmost
  localparam logic [UVRA_SLOT_COUNT-1:0][15:0] UVRA_SLOT_INDEX = {
    UVRA_IDX_EMPTY_PACKET_FLAG_ENABLE, UVRA_IDX_EMPTY_PACKET_CTL_SECOND,
    UVRA_IDX_EMPTY_PACKET_CTL_FIRST, UVRA_IDX_RECEIVE_SAMPLE_POINT,
    UVRA_IDX_PORT2_CHAR_GAP, UVRA_IDX_PORT1_CHAR_GAP,
    UVRA_IDX_CLOCK_CHOICE_SECOND, UVRA_IDX_CLOCK_CHOICE_FIRST,
    UVRA_IDX_CLOCK_SOURCE_MUX, UVRA_IDX_SYNTH_DIVIDER,
    UVRA_IDX_SYNTH_MULTIPLIER, UVRA_IDX_PORT2_CONTROL,
    UVRA_IDX_PORT2_LINE_SETUP, UVRA_IDX_BUFFER_TOGGLE_LOWER,
    UVRA_IDX_BUFFER_TOGGLE_UPPER, UVRA_IDX_PORT1_CONTROL,
    UVRA_IDX_PORT1_LINE_SETUP};

  localparam logic [UVRA_SLOT_COUNT-1:0][7:0] UVRA_SLOT_MASK = {
    UVRA_MASK_FULL, UVRA_MASK_FULL, UVRA_MASK_FULL, UVRA_MASK_FULL,
    UVRA_MASK_FULL, UVRA_MASK_FULL,
    UVRA_MASK_SIX, UVRA_MASK_SIX, UVRA_MASK_FOUR, UVRA_MASK_SIX,
    UVRA_MASK_SIX, UVRA_MASK_FULL, UVRA_MASK_FULL, UVRA_MASK_SEVEN,
    UVRA_MASK_FULL, UVRA_MASK_FULL, UVRA_MASK_FULL};

  // setup packet handed over by the control endpoint
  typedef struct packed {
    logic [7:0] req_type;
    logic [7:0] request;
    logic [15:0] value;
    logic [15:0] index;
    logic [15:0] length;
  } uvra_setup_type;

  // answer back to the control endpoint
  typedef struct packed {
    logic done;
    logic claimed;
    logic rd_valid;
    logic [7:0] rd_data;
  } uvra_answer_type;

  // live FIFO status bytes from the serial port logic
  typedef struct packed {
    logic [7:0] p1_up;
    logic [7:0] p1_down;
    logic [7:0] p2_up;
    logic [7:0] p2_down;
  } uvra_fifo_state_type;

endpackage

// >>> rtl/uvra_vendor_regs.sv
`timescale 1ns/1ps
module uvra_vendor_regs
  import uvra_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic setup_valid,
  input wire uvra_setup_type setup,
  input wire uvra_fifo_state_type fifo_state,
  input wire logic [7:0] mode_strap,
  output uvra_answer_type answer,
  output logic [UVRA_SLOT_COUNT-1:0][7:0] config_bytes
);

  typedef struct packed {
    logic [UVRA_SLOT_COUNT-1:0][7:0] regs;
    logic [7:0] mode_meta;
    logic [7:0] mode_sync;
    uvra_answer_type ans;
  } uvra_state_type;

  uvra_state_type state_q;
  uvra_state_type state_d;
  logic is_read;
  logic is_write;
  logic [7:0] read_byte;
  localparam logic [15:0] UVRA_IDX_UNLISTED_PROBE = 16'h0004; // a gap in the map, for checks

  // request decode; anything else is left for the endpoint to stall
  assign is_read = (setup.req_type == UVRA_REQTYPE_VENDOR_IN) &&
                   (setup.request == UVRA_REQ_READ) &&
                   (setup.value == UVRA_READ_VALUE) &&
                   (setup.length == UVRA_READ_LENGTH);
  assign is_write = (setup.req_type == UVRA_REQTYPE_VENDOR_OUT) &&
                    (setup.request == UVRA_REQ_WRITE) &&
                    (setup.length == UVRA_WRITE_LENGTH);

  // read mux: stored slots first, then live read-only status
  always_comb begin
    read_byte = UVRA_UNMAPPED_BYTE;
    for (int i = 0; i < UVRA_SLOT_COUNT; i++) begin
      if (setup.index == UVRA_SLOT_INDEX[i]) begin
        read_byte = state_q.regs[i];
      end
    end
    unique case (setup.index)
      UVRA_IDX_STRAP_MODE_STATUS: read_byte = state_q.mode_sync;
      UVRA_IDX_PORT1_UPSTREAM_FIFO: read_byte = fifo_state.p1_up;
      UVRA_IDX_PORT1_DOWNSTREAM_FIFO: read_byte = fifo_state.p1_down;
      UVRA_IDX_PORT2_UPSTREAM_FIFO: read_byte = fifo_state.p2_up;
      UVRA_IDX_PORT2_DOWNSTREAM_FIFO: read_byte = fifo_state.p2_down;
      default: ;
    endcase
  end

  // next state: one answer pulse per request, masked stores on write
  always_comb begin
    state_d = state_q;
    state_d.mode_meta = mode_strap; // strap pins are asynchronous to clk
    state_d.mode_sync = state_q.mode_meta;
    state_d.ans = '0;
    if (setup_valid) begin
      state_d.ans.done = 1'b1;
      if (is_read) begin
        state_d.ans.claimed = 1'b1;
        state_d.ans.rd_valid = 1'b1;
        state_d.ans.rd_data = read_byte;
      end else if (is_write) begin
        state_d.ans.claimed = 1'b1; // read-only or unlisted index is simply dropped
        for (int i = 0; i < UVRA_SLOT_COUNT; i++) begin
          if (setup.index == UVRA_SLOT_INDEX[i]) begin
            // bits outside the writable mask keep their stored value
            state_d.regs[i] = (state_q.regs[i] & ~UVRA_SLOT_MASK[i]) |
                              (setup.value[7:0] & UVRA_SLOT_MASK[i]);
          end
        end
      end
    end
  end

  // single state register
  always_ff @(posedge clk) begin
    if (rst) begin
      state_q.regs <= {UVRA_SLOT_COUNT{UVRA_REG_RESET}};
      state_q.mode_meta <= UVRA_REG_RESET;
      state_q.mode_sync <= UVRA_REG_RESET;
      state_q.ans <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  assign answer = state_q.ans;
  assign config_bytes = state_q.regs;

  // assertions
  sequence seq_read_at(logic [15:0] idx);
    setup_valid && is_read && (setup.index == idx);
  endsequence

  sequence seq_write_at(logic [15:0] idx);
    setup_valid && is_write && (setup.index == idx);
  endsequence

  sequence seq_odd_request;
    setup_valid && !is_read && !is_write;
  endsequence

  // slot of a stored index, so the checks can name registers by index alone
  function automatic int slot_of(input logic [15:0] idx);
    int found;
    found = 0;
    for (int i = 0; i < UVRA_SLOT_COUNT; i++) begin
      if (UVRA_SLOT_INDEX[i] == idx) begin
        found = i;
      end
    end
    return found;
  endfunction

  // a read hands back the byte stored before the taking edge
  property prop_readback(logic [15:0] idx);
    seq_read_at(idx) |=> answer.rd_data == $past(state_q.regs[slot_of(idx)]);
  endproperty

  // a write keeps bits outside the mask and takes the low value byte inside it
  property prop_masked_write(logic [15:0] idx, logic [7:0] wmask);
    seq_write_at(idx) |=> state_q.regs[slot_of(idx)] ==
      (($past(state_q.regs[slot_of(idx)]) & ~wmask) | ($past(setup.value[7:0]) & wmask));
  endproperty

  AST_READ_ANSWER: assert property (@(posedge clk) disable iff (rst)
    setup_valid && is_read |=> answer.done && answer.claimed && answer.rd_valid
      ##1 (!answer.done || $past(setup_valid)))
    else $error("read request not answered with one data byte");

  AST_WRITE_ANSWER: assert property (@(posedge clk) disable iff (rst)
    setup_valid && is_write |=> answer.done && answer.claimed && !answer.rd_valid)
    else $error("write request not acknowledged");

  AST_LINE_READBACK: assert property (@(posedge clk) disable iff (rst)
    seq_read_at(UVRA_IDX_PORT2_LINE_SETUP) |=>
      answer.rd_data == $past(state_q.regs[UVRA_SLOT_P2_LINE]))
    else $error("port2 line setup readback wrong");

  AST_WRITE_THEN_READ: assert property (@(posedge clk) disable iff (rst)
    seq_write_at(UVRA_IDX_PORT1_LINE_SETUP) ##1 seq_read_at(UVRA_IDX_PORT1_LINE_SETUP)
      |=> answer.rd_data == $past(setup.value[7:0], 2))
    else $error("port1 line setup did not return written byte");

  AST_MULT_MASK: assert property (@(posedge clk) disable iff (rst)
    seq_write_at(UVRA_IDX_SYNTH_MULTIPLIER) |=>
      state_q.regs[UVRA_SLOT_MULT][5:0] == $past(setup.value[5:0]) &&
      state_q.regs[UVRA_SLOT_MULT][7:6] == $past(state_q.regs[UVRA_SLOT_MULT][7:6]))
    else $error("multiplier write mask wrong");

  AST_MUX_MASK: assert property (@(posedge clk) disable iff (rst)
    seq_write_at(UVRA_IDX_CLOCK_SOURCE_MUX) |=>
      state_q.regs[UVRA_SLOT_MUX][3:0] == $past(setup.value[3:0]) &&
      state_q.regs[UVRA_SLOT_MUX][7:4] == $past(state_q.regs[UVRA_SLOT_MUX][7:4]))
    else $error("clock mux write mask wrong");

  AST_TOGGLE_MASK: assert property (@(posedge clk) disable iff (rst)
    seq_write_at(UVRA_IDX_BUFFER_TOGGLE_LOWER) |=>
      state_q.regs[UVRA_SLOT_TOG_LOWER][6:0] == $past(setup.value[6:0]) &&
      state_q.regs[UVRA_SLOT_TOG_LOWER][7] == $past(state_q.regs[UVRA_SLOT_TOG_LOWER][7]))
    else $error("buffer toggle lower write mask wrong");

  AST_RO_WRITE: assert property (@(posedge clk) disable iff (rst)
    seq_write_at(UVRA_IDX_STRAP_MODE_STATUS) |=>
      answer.claimed && state_q.regs == $past(state_q.regs))
    else $error("write to read-only register changed state");

  AST_MODE_READ: assert property (@(posedge clk) disable iff (rst)
    seq_read_at(UVRA_IDX_STRAP_MODE_STATUS) |=> answer.rd_data == $past(state_q.mode_sync))
    else $error("mode status read wrong");

  AST_FIFO_READ: assert property (@(posedge clk) disable iff (rst)
    seq_read_at(UVRA_IDX_PORT1_UPSTREAM_FIFO) |=> answer.rd_data == $past(fifo_state.p1_up))
    else $error("port1 upstream FIFO state read wrong");

  AST_FIFO2_READ: assert property (@(posedge clk) disable iff (rst)
    seq_read_at(UVRA_IDX_PORT2_DOWNSTREAM_FIFO) |=>
      answer.rd_data == $past(fifo_state.p2_down))
    else $error("port2 downstream FIFO state read wrong");

  AST_UNMAPPED_ZERO: assert property (@(posedge clk) disable iff (rst)
    seq_read_at(UVRA_IDX_UNLISTED_PROBE) |=>
      answer.done && answer.claimed && answer.rd_data == UVRA_UNMAPPED_BYTE)
    else $error("unlisted index did not read zero");

  // answers stand one cycle and carry no data without a read
  AST_IDLE_QUIET: assert property (@(posedge clk) disable iff (rst)
    !setup_valid |=> answer == '0)
    else $error("answer present without a request");

  AST_DONE_EACH: assert property (@(posedge clk) disable iff (rst)
    setup_valid |=> answer.done)
    else $error("request left without an answer");

  AST_ODD_UNCLAIMED: assert property (@(posedge clk) disable iff (rst)
    seq_odd_request |=> answer.done && !answer.claimed && !answer.rd_valid)
    else $error("malformed request was claimed");

  AST_ODD_NO_STORE: assert property (@(posedge clk) disable iff (rst)
    seq_odd_request |=> state_q.regs == $past(state_q.regs))
    else $error("malformed request changed a register");

  AST_WRITE_NO_DATA: assert property (@(posedge clk) disable iff (rst)
    setup_valid && is_write |=> answer.rd_data == '0)
    else $error("write answer carried read data");

  // readback of the remaining stored registers
  AST_P1_LINE_READ: assert property (@(posedge clk) disable iff (rst)
    prop_readback(UVRA_IDX_PORT1_LINE_SETUP))
    else $error("port1 line setup readback wrong");

  AST_P1_CTL_READ: assert property (@(posedge clk) disable iff (rst)
    prop_readback(UVRA_IDX_PORT1_CONTROL))
    else $error("port1 control readback wrong");

  AST_P2_CTL_READ: assert property (@(posedge clk) disable iff (rst)
    prop_readback(UVRA_IDX_PORT2_CONTROL))
    else $error("port2 control readback wrong");

  AST_TOG_UP_READ: assert property (@(posedge clk) disable iff (rst)
    prop_readback(UVRA_IDX_BUFFER_TOGGLE_UPPER))
    else $error("buffer toggle upper readback wrong");

  AST_TOG_LOW_READ: assert property (@(posedge clk) disable iff (rst)
    prop_readback(UVRA_IDX_BUFFER_TOGGLE_LOWER))
    else $error("buffer toggle lower readback wrong");

  AST_MULT_READ: assert property (@(posedge clk) disable iff (rst)
    prop_readback(UVRA_IDX_SYNTH_MULTIPLIER))
    else $error("multiplier readback wrong");

  AST_DIV_READ: assert property (@(posedge clk) disable iff (rst)
    prop_readback(UVRA_IDX_SYNTH_DIVIDER))
    else $error("divider readback wrong");

  AST_MUX_READ: assert property (@(posedge clk) disable iff (rst)
    prop_readback(UVRA_IDX_CLOCK_SOURCE_MUX))
    else $error("clock mux readback wrong");

  AST_CHOICE1_READ: assert property (@(posedge clk) disable iff (rst)
    prop_readback(UVRA_IDX_CLOCK_CHOICE_FIRST))
    else $error("first clock choice readback wrong");

  AST_CHOICE2_READ: assert property (@(posedge clk) disable iff (rst)
    prop_readback(UVRA_IDX_CLOCK_CHOICE_SECOND))
    else $error("second clock choice readback wrong");

  AST_GAP1_READ: assert property (@(posedge clk) disable iff (rst)
    prop_readback(UVRA_IDX_PORT1_CHAR_GAP))
    else $error("port1 character gap readback wrong");

  AST_GAP2_READ: assert property (@(posedge clk) disable iff (rst)
    prop_readback(UVRA_IDX_PORT2_CHAR_GAP))
    else $error("port2 character gap readback wrong");

  AST_SAMPLE_READ: assert property (@(posedge clk) disable iff (rst)
    prop_readback(UVRA_IDX_RECEIVE_SAMPLE_POINT))
    else $error("receive sample point readback wrong");

  AST_EMPTY1_READ: assert property (@(posedge clk) disable iff (rst)
    prop_readback(UVRA_IDX_EMPTY_PACKET_CTL_FIRST))
    else $error("first empty packet control readback wrong");

  AST_EMPTY2_READ: assert property (@(posedge clk) disable iff (rst)
    prop_readback(UVRA_IDX_EMPTY_PACKET_CTL_SECOND))
    else $error("second empty packet control readback wrong");

  AST_FLAG_EN_READ: assert property (@(posedge clk) disable iff (rst)
    prop_readback(UVRA_IDX_EMPTY_PACKET_FLAG_ENABLE))
    else $error("empty packet flag enable readback wrong");

  // stores of the remaining registers, high value byte never reaches them
  AST_P1_LINE_WRITE: assert property (@(posedge clk) disable iff (rst)
    prop_masked_write(UVRA_IDX_PORT1_LINE_SETUP, UVRA_MASK_FULL))
    else $error("port1 line setup store wrong");

  AST_P2_LINE_WRITE: assert property (@(posedge clk) disable iff (rst)
    prop_masked_write(UVRA_IDX_PORT2_LINE_SETUP, UVRA_MASK_FULL))
    else $error("port2 line setup store wrong");

  AST_P1_CTL_WRITE: assert property (@(posedge clk) disable iff (rst)
    prop_masked_write(UVRA_IDX_PORT1_CONTROL, UVRA_MASK_FULL))
    else $error("port1 control store wrong");

  AST_P2_CTL_WRITE: assert property (@(posedge clk) disable iff (rst)
    prop_masked_write(UVRA_IDX_PORT2_CONTROL, UVRA_MASK_FULL))
    else $error("port2 control store wrong");

  AST_TOG_UP_WRITE: assert property (@(posedge clk) disable iff (rst)
    prop_masked_write(UVRA_IDX_BUFFER_TOGGLE_UPPER, UVRA_MASK_FULL))
    else $error("buffer toggle upper store wrong");

  AST_DIV_MASK: assert property (@(posedge clk) disable iff (rst)
    prop_masked_write(UVRA_IDX_SYNTH_DIVIDER, UVRA_MASK_SIX))
    else $error("divider write mask wrong");

  AST_CHOICE1_MASK: assert property (@(posedge clk) disable iff (rst)
    prop_masked_write(UVRA_IDX_CLOCK_CHOICE_FIRST, UVRA_MASK_SIX))
    else $error("first clock choice write mask wrong");

  AST_CHOICE2_MASK: assert property (@(posedge clk) disable iff (rst)
    prop_masked_write(UVRA_IDX_CLOCK_CHOICE_SECOND, UVRA_MASK_SIX))
    else $error("second clock choice write mask wrong");

  AST_GAP1_WRITE: assert property (@(posedge clk) disable iff (rst)
    prop_masked_write(UVRA_IDX_PORT1_CHAR_GAP, UVRA_MASK_FULL))
    else $error("port1 character gap store wrong");

  AST_GAP2_WRITE: assert property (@(posedge clk) disable iff (rst)
    prop_masked_write(UVRA_IDX_PORT2_CHAR_GAP, UVRA_MASK_FULL))
    else $error("port2 character gap store wrong");

  AST_SAMPLE_WRITE: assert property (@(posedge clk) disable iff (rst)
    prop_masked_write(UVRA_IDX_RECEIVE_SAMPLE_POINT, UVRA_MASK_FULL))
    else $error("receive sample point store wrong");

  AST_EMPTY1_WRITE: assert property (@(posedge clk) disable iff (rst)
    prop_masked_write(UVRA_IDX_EMPTY_PACKET_CTL_FIRST, UVRA_MASK_FULL))
    else $error("first empty packet control store wrong");

  AST_EMPTY2_WRITE: assert property (@(posedge clk) disable iff (rst)
    prop_masked_write(UVRA_IDX_EMPTY_PACKET_CTL_SECOND, UVRA_MASK_FULL))
    else $error("second empty packet control store wrong");

  AST_FLAG_EN_WRITE: assert property (@(posedge clk) disable iff (rst)
    prop_masked_write(UVRA_IDX_EMPTY_PACKET_FLAG_ENABLE, UVRA_MASK_FULL))
    else $error("empty packet flag enable store wrong");

  // live status bytes and writes that must change nothing
  AST_FIFO1_DOWN_READ: assert property (@(posedge clk) disable iff (rst)
    seq_read_at(UVRA_IDX_PORT1_DOWNSTREAM_FIFO) |=>
      answer.rd_data == $past(fifo_state.p1_down))
    else $error("port1 downstream FIFO state read wrong");

  AST_FIFO2_UP_READ: assert property (@(posedge clk) disable iff (rst)
    seq_read_at(UVRA_IDX_PORT2_UPSTREAM_FIFO) |=>
      answer.rd_data == $past(fifo_state.p2_up))
    else $error("port2 upstream FIFO state read wrong");

  AST_FIFO_RO_WRITE: assert property (@(posedge clk) disable iff (rst)
    seq_write_at(UVRA_IDX_PORT2_UPSTREAM_FIFO) |=>
      answer.claimed && state_q.regs == $past(state_q.regs))
    else $error("write to FIFO state changed a register");

  AST_UNLISTED_WRITE: assert property (@(posedge clk) disable iff (rst)
    seq_write_at(UVRA_IDX_UNLISTED_PROBE) |=>
      answer.claimed && state_q.regs == $past(state_q.regs))
    else $error("write to unlisted index changed a register");

  // the strap byte needs two clean edges after reset before it can be compared
  AST_MODE_SYNC: assert property (@(posedge clk) disable iff (rst)
    !$past(rst) && !$past(rst, 2) |-> state_q.mode_sync == $past(mode_strap, 2))
    else $error("mode strap synchroniser depth wrong");

endmodule

// >>> verification/uvra_host_model.sv
`timescale 1ns/1ps
// usb host issuing vendor control requests on the default endpoint
module uvra_host_model
  import uvra_pkg::*;
(
  input wire logic clk,
  input wire uvra_answer_type answer,
  output logic setup_valid,
  output uvra_setup_type setup
);
  initial begin
    setup_valid = 1'b0;
    setup = '0;
  end
  // one setup packet, then the answer as it stands just after the taking edge
  task automatic xfer(input logic [7:0] rt, input logic [7:0] rq, input logic [15:0] val,
      input logic [15:0] idx, input logic [15:0] len, output uvra_answer_type ans);
    setup_valid = 1'b1;
    setup = '{req_type: rt, request: rq, value: val, index: idx, length: len};
    @(posedge clk);
    #1;
    // the answer stands only in the cycle right after the taking edge
    ans = answer;
    // a released packet shows inverted bits so a stale latch cannot pass by luck
    setup_valid = 1'b0;
    setup = ~setup;
    @(posedge clk);
    #1;
  endtask
  task automatic rd(input logic [15:0] idx, output uvra_answer_type ans);
    xfer(UVRA_REQTYPE_VENDOR_IN, UVRA_REQ_READ, UVRA_READ_VALUE, idx, UVRA_READ_LENGTH, ans);
  endtask
  // high byte of the value field is junk on purpose, only the low byte counts
  task automatic wr(input logic [15:0] idx, input logic [7:0] d, output uvra_answer_type ans);
    xfer(UVRA_REQTYPE_VENDOR_OUT, UVRA_REQ_WRITE, {8'hA5, d}, idx, UVRA_WRITE_LENGTH, ans);
  endtask
  // write then read of one index on consecutive edges, valid held high between them
  task automatic wr_rd(input logic [15:0] idx, input logic [7:0] d, output uvra_answer_type wa,
      output uvra_answer_type ra);
    setup_valid = 1'b1;
    setup = '{req_type: UVRA_REQTYPE_VENDOR_OUT, request: UVRA_REQ_WRITE,
      value: {8'hA5, d}, index: idx, length: UVRA_WRITE_LENGTH};
    @(posedge clk);
    #1;
    wa = answer;
    setup = '{req_type: UVRA_REQTYPE_VENDOR_IN, request: UVRA_REQ_READ,
      value: UVRA_READ_VALUE, index: idx, length: UVRA_READ_LENGTH};
    @(posedge clk);
    #1;
    ra = answer;
    setup_valid = 1'b0;
    setup = ~setup;
    @(posedge clk);
    #1;
  endtask
endmodule

// >>> verification/tb_usb_vendor_register_access.sv
`timescale 1ns/1ps
module tb_usb_vendor_register_access;
  import uvra_pkg::*;
  logic clk;
  logic rst;
  logic setup_valid;
  uvra_setup_type setup;
  uvra_fifo_state_type fifo_state;
  logic [7:0] mode_strap;
  uvra_answer_type answer;
  logic [UVRA_SLOT_COUNT-1:0][7:0] config_bytes;
  logic [UVRA_SLOT_COUNT-1:0][7:0] shadow;
  int n_fail;
  int total_checks;

  uvra_vendor_regs dut_u (.clk(clk), .rst(rst), .setup_valid(setup_valid), .setup(setup),
    .fifo_state(fifo_state), .mode_strap(mode_strap), .answer(answer),
    .config_bytes(config_bytes));
  uvra_host_model host_u (.clk(clk), .answer(answer), .setup_valid(setup_valid),
    .setup(setup));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic chk(input logic [UVRA_SLOT_COUNT*8-1:0] got,
      input logic [UVRA_SLOT_COUNT*8-1:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic final_report();
    $display("checks=%0d failures=%0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // answer of a good read: done, claimed, data present, byte
  function automatic logic [15:0] rd_ok(input logic [7:0] d);
    return {5'h00, 3'b111, d};
  endfunction

  // distinct bytes into every slot, then read all back, so two slots sharing one index show
  task automatic t_write_all(input logic [7:0] seed);
    uvra_answer_type a;
    logic [7:0] d;
    for (int s = 0; s < UVRA_SLOT_COUNT; s++) begin
      d = seed ^ 8'(s * 11);
      host_u.wr(UVRA_SLOT_INDEX[s], d, a);
      chk(a, 16'h0600);
      shadow[s] = (d & UVRA_SLOT_MASK[s]) | (shadow[s] & ~UVRA_SLOT_MASK[s]);
    end
    chk(config_bytes, shadow);
    for (int s = 0; s < UVRA_SLOT_COUNT; s++) begin
      host_u.rd(UVRA_SLOT_INDEX[s], a);
      chk(a, rd_ok(shadow[s]));
    end
  endtask

  // status bytes follow live inputs; writes to them are taken and change nothing
  task automatic t_read_only();
    uvra_answer_type a;
    logic [39:0] live;
    logic [15:0] idx [5];
    live = {mode_strap, fifo_state};
    idx = '{UVRA_IDX_STRAP_MODE_STATUS, UVRA_IDX_PORT1_UPSTREAM_FIFO,
      UVRA_IDX_PORT1_DOWNSTREAM_FIFO, UVRA_IDX_PORT2_UPSTREAM_FIFO,
      UVRA_IDX_PORT2_DOWNSTREAM_FIFO};
    for (int k = 0; k < 5; k++) begin
      host_u.wr(idx[k], 8'h3C, a);
      chk(a, 16'h0600);
      chk(config_bytes, shadow);
      host_u.rd(idx[k], a);
      chk(a, rd_ok(live[39-8*k -: 8]));
    end
  endtask

  // unlisted index reads zero; malformed requests are answered but not claimed
  task automatic t_odd();
    uvra_answer_type a;
    host_u.rd(16'h0004, a);
    chk(a, rd_ok(8'h00));
    @(posedge clk);
    #1;
    chk(answer, 16'h0000);
    host_u.wr(16'h0004, 8'h77, a);
    chk(a, 16'h0600);
    chk(config_bytes, shadow);
    host_u.xfer(UVRA_REQTYPE_VENDOR_IN, UVRA_REQ_READ, 16'h0001, UVRA_IDX_PORT1_CONTROL,
      UVRA_READ_LENGTH, a);
    chk(a, 16'h0400);
    host_u.xfer(UVRA_REQTYPE_VENDOR_OUT, UVRA_REQ_READ, 16'h0011, 16'h0000, 16'h0000, a);
    chk(a, 16'h0400);
    chk(config_bytes, shadow);
  endtask

  // write and read one index on consecutive edges; the read must see the new byte
  task automatic t_back_to_back();
    uvra_answer_type wa;
    uvra_answer_type ra;
    logic [7:0] d;
    for (int s = 0; s < UVRA_SLOT_COUNT; s++) begin
      d = 8'hC3 ^ 8'(s * 7);
      host_u.wr_rd(UVRA_SLOT_INDEX[s], d, wa, ra);
      shadow[s] = (d & UVRA_SLOT_MASK[s]) | (shadow[s] & ~UVRA_SLOT_MASK[s]);
      chk(wa, 16'h0600);
      chk(ra, rd_ok(shadow[s]));
    end
  endtask

  // reset in mid-run clears stores and answer; a request may follow at once
  task automatic t_reset_mid();
    uvra_answer_type a;
    rst = 1'b1;
    repeat (2) @(posedge clk);
    #1;
    chk(config_bytes, '0);
    chk(answer, 16'h0000);
    rst = 1'b0;
    shadow = '0;
    host_u.rd(UVRA_IDX_SYNTH_MULTIPLIER, a);
    chk(a, rd_ok(8'h00));
  endtask

  initial begin
    n_fail = 0;
    total_checks = 0;
    shadow = '0;
    rst = 1'b1;
    fifo_state = 32'h11223344;
    mode_strap = 8'h5A;
    repeat (2) @(posedge clk);
    #1;
    rst = 1'b0;
    chk(config_bytes, '0);
    t_write_all(8'hFF);
    t_write_all(8'h5A);
    t_back_to_back();
    t_read_only();
    fifo_state = 32'hC3E1F087;
    mode_strap = 8'hA6;
    t_read_only();
    t_reset_mid();
    t_odd();
    final_report();
  end

  // the sequence needs a few hundred cycles; this cuts a hang short
  initial begin
    #50000;
    n_fail++;
    final_report();
  end
endmodule
